// *** hdl/sct_pkg.sv ***
// constants, register map and types of the slow clock system timer
// assumes a 32-bit ahb-lite register bus and a slow clock pin near 32768 Hz
package sct_pkg;

  // ----------------------------------------
  // clock figures
  // ----------------------------------------
  localparam int SLOW_CLOCK_HZ = 32768;            // nominal slow clock rate
  localparam int MASTER_CLOCK_HZ = 100000000;      // i_clk rate
  localparam int GUARD_DIV = 128;                  // watchdog prescale ratio
  localparam int GUARD_DIV_W = $clog2(GUARD_DIV);  // prescaler width

  // ----------------------------------------
  // register byte offsets (low address byte)
  // ----------------------------------------
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INTERVAL_MODE = 8'h04;
  localparam logic [7:0] OFS_WATCHDOG_MODE = 8'h08;
  localparam logic [7:0] OFS_SECONDS_MODE = 8'h0c;
  localparam logic [7:0] OFS_TIMER_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_DISABLE = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_SECONDS_ALARM = 8'h20;
  localparam logic [7:0] OFS_SECONDS_CURRENT = 8'h24;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int GUARD_RESTART_BIT = 0;       // in timer_control
  localparam int RESET_ENABLE_BIT = 16;       // in watchdog_mode
  localparam int EXTERNAL_SIGNAL_ENABLE_BIT = 17;
  localparam int INTERVAL_W = 16;
  localparam int GUARD_W = 16;
  localparam int WD_MODE_W = 18;
  localparam int PRES_W = 16;
  localparam int SECONDS_W = 20;
  localparam int FLAG_W = 4;
  localparam int FLAG_INTERVAL = 0;           // interval_elapsed_flag
  localparam int FLAG_GUARD = 1;              // guard_overflow_flag
  localparam int FLAG_TICK = 2;               // seconds_tick_flag
  localparam int FLAG_ALARM = 3;              // alarm_match_flag

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 16'h0000;
  localparam logic [WD_MODE_W-1:0] WD_MODE_RST = 18'h20000;
  localparam logic [PRES_W-1:0] PRES_RST = 16'h8000;
  localparam logic [SECONDS_W-1:0] ALARM_RST = 20'h00000;
  localparam logic [3:0] GUARD_PULSE_SLOW = 4'h8;  // low time of overflow pin

  // ----------------------------------------
  // bus slave phases
  // ----------------------------------------
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ_WAIT, BUS_READ, BUS_WRITE} sct_bus_e;

endpackage

// *** hdl/sct_slow_edge.sv ***
// slow clock pin synchroniser with a rising edge pulse out
// assumes the pin is asynchronous to i_clk and much slower than it
`timescale 1ns/10ps
module sct_slow_edge (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // slow clock pin
  input wire logic i_pin,
  // one i_clk cycle per slow rising edge
  output logic o_rise
);
  import sct_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic meta;  // first stage, read only by second
    logic sync;  // second stage
    logic prev;  // delayed copy for edge detection
  } sct_edge_s;

  sct_edge_s state_reg;
  sct_edge_s state_next;

  // shift the pin through the stages
  always_comb begin
    state_next = state_reg;
    state_next.meta = i_pin;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  // register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // edge pulse from synchronised stages only
  assign o_rise = state_reg.sync & ~state_reg.prev;

endmodule

// *** hdl/sct_down_counter.sv ***
// reloading down counter: a load value of 0 means 2**W ticks
// assumes i_tick is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module sct_down_counter #(
  parameter int W = 16,
  parameter logic [W-1:0] RST_VALUE = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic [W-1:0] i_reload,
  input wire logic [W-1:0] i_load_value,
  // status
  output logic [W-1:0] o_count,
  output logic o_zero
);
  import sct_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0] count;  // ticks left before the zero event
  } sct_cnt_s;

  sct_cnt_s state_reg;
  sct_cnt_s state_next;
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  // zero event on the last tick, unless a load takes over
  assign o_zero = i_tick & ~i_load & (state_reg.count == ONE);

  // load wins, then reload at zero, else count down
  always_comb begin
    state_next = state_reg;
    if (i_load) begin
      state_next.count = i_load_value;
    end else if (o_zero) begin
      state_next.count = i_reload;
    end else if (i_tick) begin
      state_next.count = state_reg.count - ONE;
    end
  end

  // register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= RST_VALUE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_count = state_reg.count;

endmodule

// *** hdl/sct_system_timer.sv ***
// system timer: interval tick, watchdog and seconds counter on the slow clock
// assumes an ahb-lite master on i_clk and a slow clock pin asynchronous to it
//
// Operation
// - runs on slow clock, power settings ignored
// - 16-bit interval counter, zero means maximum
// - interval zero sets flag, may interrupt
// - interval counter reloads itself at zero
// - interval mode write reloads, restarts counter
// - 16-bit watchdog, mode resets to maximum
// - watchdog counts slow clock over 128
// - control write with restart bit set reloads watchdog and prescaler
// - watchdog overflow sets its status flag
// - overflow pin low eight slow cycles
// - overflow with reset enable requests reset
// - watchdog reloads and restarts after overflow
// - watchdog mode write does not reload
// - 20-bit seconds counter, prescaler resets 0x8000
// - seconds counter wraps after 1048576 states
// - alarm compare sets flag, zero means maximum
// - each seconds increment sets tick flag
// - seconds mode write restarts prescaler, clears counter
// - status flags clear when status is read
// - enable sets, disable clears mask bits
// - watchdog mode holds value, reset, external enables
`timescale 1ns/10ps
module sct_system_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // slow clock pin
  input wire logic i_slow_clock,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // system outputs
  output logic o_irq,
  output logic o_guard_overflow_out_n,
  output logic o_reset_request
);
  import sct_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sct_bus_e bus;                          // bus slave phase
    logic [7:0] addr;                       // latched low address byte
    logic [31:0] rdata;                     // read data for the bus
    logic [INTERVAL_W-1:0] interval_mode;   // interval value
    logic [WD_MODE_W-1:0] watchdog_mode;    // enables and reload value
    logic [PRES_W-1:0] seconds_mode;        // seconds_prescaler
    logic [SECONDS_W-1:0] seconds_alarm;    // alarm value
    logic [SECONDS_W-1:0] seconds_current;  // seconds count
    logic [FLAG_W-1:0] status;              // sticky event flags
    logic [FLAG_W-1:0] mask;                // interrupt mask
    logic [3:0] pulse_left;                 // slow cycles of low pin left
    logic guard_out_n;                      // overflow pin, active low
    logic reset_request;                    // internal reset pulse
  } sct_state_s;

  sct_state_s state_reg;
  sct_state_s state_next;

  // ----------------------------------------
  // decode of the write data phase
  // ----------------------------------------
  logic slow_tick;       // one cycle per slow clock rising edge
  logic wr_phase;        // write data phase this cycle
  logic wr_control;      // timer_control written
  logic wr_interval;     // interval_mode written
  logic wr_watchdog;     // watchdog_mode written
  logic wr_seconds;      // seconds_mode written
  logic guard_restart;   // restart bit written as one
  logic interval_zero;   // interval counter reached zero
  logic pres_zero;       // watchdog prescaler wrapped
  logic guard_zero;      // watchdog overflow
  logic seconds_zero;    // seconds prescaler period done
  logic alarm_hit;       // increment lands on the alarm value
  logic accept;          // new address phase taken
  logic [SECONDS_W-1:0] seconds_inc;          // count plus one, wraps
  logic [INTERVAL_W-1:0] interval_count;      // interval counter value
  logic [GUARD_W-1:0] guard_count;            // watchdog counter value
  logic [GUARD_DIV_W-1:0] pres_count;         // watchdog prescaler value

  assign wr_phase = (state_reg.bus == BUS_WRITE);
  assign wr_control = wr_phase & (state_reg.addr == OFS_TIMER_CONTROL);
  assign wr_interval = wr_phase & (state_reg.addr == OFS_INTERVAL_MODE);
  assign wr_watchdog = wr_phase & (state_reg.addr == OFS_WATCHDOG_MODE);
  assign wr_seconds = wr_phase & (state_reg.addr == OFS_SECONDS_MODE);
  assign guard_restart = wr_control & i_hwdata[GUARD_RESTART_BIT];
  assign accept = i_hsel & i_htrans[1] & i_hready;
  assign seconds_inc = state_reg.seconds_current + {{(SECONDS_W-1){1'b0}}, 1'b1};
  assign alarm_hit = seconds_zero & (seconds_inc == state_reg.seconds_alarm);

  // ----------------------------------------
  // slow clock and counters
  // ----------------------------------------
  // only the slow clock paces the timers; no power input exists
  sct_slow_edge u_slow_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_slow_clock),
    .o_rise(slow_tick)
  );

  // interval counter, reloads itself and on mode writes
  sct_down_counter #(.W(INTERVAL_W), .RST_VALUE(INTERVAL_RST)) u_interval (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(slow_tick),
    .i_load(wr_interval),
    .i_reload(state_reg.interval_mode),
    .i_load_value(i_hwdata[INTERVAL_W-1:0]),
    .o_count(interval_count),
    .o_zero(interval_zero)
  );

  // divide by 128, restarted by the restart bit
  sct_down_counter #(.W(GUARD_DIV_W), .RST_VALUE('0)) u_guard_pres (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(slow_tick),
    .i_load(guard_restart),
    .i_reload('0),
    .i_load_value('0),
    .o_count(pres_count),
    .o_zero(pres_zero)
  );

  // watchdog counter, reloads from the stored mode value
  sct_down_counter #(.W(GUARD_W), .RST_VALUE(WD_MODE_RST[GUARD_W-1:0])) u_guard (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(pres_zero),
    .i_load(guard_restart),
    .i_reload(state_reg.watchdog_mode[GUARD_W-1:0]),
    .i_load_value(state_reg.watchdog_mode[GUARD_W-1:0]),
    .o_count(guard_count),
    .o_zero(guard_zero)
  );

  // seconds prescaler, restarted with the new value on mode writes
  sct_down_counter #(.W(PRES_W), .RST_VALUE(PRES_RST)) u_seconds_pres (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(slow_tick),
    .i_load(wr_seconds),
    .i_reload(state_reg.seconds_mode),
    .i_load_value(i_hwdata[PRES_W-1:0]),
    .o_count(),
    .o_zero(seconds_zero)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.reset_request = guard_zero & state_reg.watchdog_mode[RESET_ENABLE_BIT];
    // seconds counter: cleared by mode write, else wraps on increment
    if (wr_seconds) begin
      state_next.seconds_current = '0;
    end else if (seconds_zero) begin
      state_next.seconds_current = seconds_inc;
    end
    // overflow pin: load eight slow cycles, count them off
    if (guard_zero & state_reg.watchdog_mode[EXTERNAL_SIGNAL_ENABLE_BIT]) begin
      state_next.pulse_left = GUARD_PULSE_SLOW;
    end else if (slow_tick & (state_reg.pulse_left != 4'h0)) begin
      state_next.pulse_left = state_reg.pulse_left - 4'h1;
    end
    state_next.guard_out_n = (state_next.pulse_left == 4'h0);
    // register writes in the data phase
    if (wr_phase) begin
      case (state_reg.addr)
        OFS_INTERVAL_MODE: begin
          state_next.interval_mode = i_hwdata[INTERVAL_W-1:0];
        end
        OFS_WATCHDOG_MODE: begin
          state_next.watchdog_mode = i_hwdata[WD_MODE_W-1:0];
        end
        OFS_SECONDS_MODE: begin
          state_next.seconds_mode = i_hwdata[PRES_W-1:0];
        end
        OFS_IRQ_ENABLE: begin
          state_next.mask = state_reg.mask | i_hwdata[FLAG_W-1:0];
        end
        OFS_IRQ_DISABLE: begin
          state_next.mask = state_reg.mask & ~i_hwdata[FLAG_W-1:0];
        end
        OFS_SECONDS_ALARM: begin
          state_next.seconds_alarm = i_hwdata[SECONDS_W-1:0];
        end
        default: begin
          // read-only, control or unmapped: nothing stored
        end
      endcase
    end
    // read: sample in the wait cycle, clear flags on status read
    if (state_reg.bus == BUS_READ_WAIT) begin
      case (state_reg.addr)
        OFS_INTERVAL_MODE: state_next.rdata = 32'(state_reg.interval_mode);
        OFS_WATCHDOG_MODE: state_next.rdata = 32'(state_reg.watchdog_mode);
        OFS_SECONDS_MODE: state_next.rdata = 32'(state_reg.seconds_mode);
        OFS_TIMER_STATUS: state_next.rdata = 32'(state_reg.status);
        OFS_IRQ_MASK: state_next.rdata = 32'(state_reg.mask);
        OFS_SECONDS_ALARM: state_next.rdata = 32'(state_reg.seconds_alarm);
        OFS_SECONDS_CURRENT: state_next.rdata = 32'(state_reg.seconds_current);
        default: state_next.rdata = 32'h00000000;
      endcase
      if (state_reg.addr == OFS_TIMER_STATUS) begin
        state_next.status = '0;
      end
    end
    // events set flags after any clear, so set wins
    state_next.status[FLAG_INTERVAL] = state_next.status[FLAG_INTERVAL] | interval_zero;
    state_next.status[FLAG_GUARD] = state_next.status[FLAG_GUARD] | guard_zero;
    state_next.status[FLAG_TICK] = state_next.status[FLAG_TICK] | seconds_zero;
    state_next.status[FLAG_ALARM] = state_next.status[FLAG_ALARM] | alarm_hit;
    // bus phase sequencing
    case (state_reg.bus)
      BUS_READ_WAIT: begin
        state_next.bus = BUS_READ;
      end
      BUS_IDLE, BUS_READ, BUS_WRITE: begin
        if (accept) begin
          state_next.addr = i_haddr[7:0];
          state_next.bus = i_hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end else begin
          state_next.bus = BUS_IDLE;
        end
      end
      default: begin
        state_next.bus = BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg.bus <= BUS_IDLE;
      state_reg.addr <= 8'h00;
      state_reg.rdata <= 32'h00000000;
      state_reg.interval_mode <= INTERVAL_RST;
      state_reg.watchdog_mode <= WD_MODE_RST;
      state_reg.seconds_mode <= PRES_RST;
      state_reg.seconds_alarm <= ALARM_RST;
      state_reg.seconds_current <= '0;
      state_reg.status <= '0;
      state_reg.mask <= '0;
      state_reg.pulse_left <= 4'h0;
      state_reg.guard_out_n <= 1'b1;
      state_reg.reset_request <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_hrdata = state_reg.rdata;
  assign o_hreadyout = (state_reg.bus != BUS_READ_WAIT);
  assign o_hresp = 1'b0;
  assign o_irq = |(state_reg.status & state_reg.mask);
  assign o_guard_overflow_out_n = state_reg.guard_out_n;
  assign o_reset_request = state_reg.reset_request;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_interval_flag;
    interval_zero |=> state_reg.status[FLAG_INTERVAL] ##1 1'b1;
  endproperty
  a_interval_flag: assert property (p_interval_flag) else $error("interval flag not set");

  property p_interval_write;
    wr_interval |=> (interval_count == $past(i_hwdata[INTERVAL_W-1:0]));
  endproperty
  a_interval_write: assert property (p_interval_write) else $error("interval not reloaded");

  property p_mode_no_reload;
    (wr_watchdog & ~pres_zero) |=> (guard_count == $past(guard_count));
  endproperty
  a_mode_no_reload: assert property (p_mode_no_reload) else $error("mode write reloaded");

  property p_restart;
    guard_restart |=> (pres_count == '0) &&
      (guard_count == $past(state_reg.watchdog_mode[GUARD_W-1:0]));
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not reload");

  property p_pin_low;
    (guard_zero & state_reg.watchdog_mode[EXTERNAL_SIGNAL_ENABLE_BIT])
      |=> !o_guard_overflow_out_n [*8];
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("overflow pin not low");

  property p_reset_req;
    guard_zero |=> (o_reset_request == $past(state_reg.watchdog_mode[RESET_ENABLE_BIT]));
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset request wrong");

  property p_seconds_clear;
    wr_seconds |=> (state_reg.seconds_current == '0);
  endproperty
  a_seconds_clear: assert property (p_seconds_clear) else $error("seconds not cleared");

  property p_seconds_inc;
    (seconds_zero & ~wr_seconds) |=> state_reg.status[FLAG_TICK] &&
      (state_reg.seconds_current == $past(seconds_inc));
  endproperty
  a_seconds_inc: assert property (p_seconds_inc) else $error("seconds increment lost");

  property p_alarm;
    alarm_hit |=> state_reg.status[FLAG_ALARM];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag not set");

  property p_status_clear;
    (state_reg.bus == BUS_READ_WAIT && state_reg.addr == OFS_TIMER_STATUS &&
      !interval_zero && !guard_zero && !seconds_zero) |=> (state_reg.status == '0);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  c_interval: cover property (interval_zero);
  c_overflow: cover property (guard_zero);
  c_alarm: cover property (alarm_hit);
  c_restart: cover property (guard_restart);

endmodule

// *** tb/sct_system_timer_tb_top.sv ***
// self-checking bench for the slow clock system timer
// assumes the bench drives the ahb-lite bus and the slow clock pin itself
`timescale 1ns/10ps
module sct_system_timer_tb_top;
  import sct_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_clk = 1'b0; // 100 mhz
  logic i_rst = 1'b1; // async reset
  logic slow = 1'b0; // slow clock pin, still between ticks
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hresp; // response code, always okay
  logic hreadyout; // also the bus hready
  logic irq;
  logic ovf_n;
  logic rst_req;
  logic rdy_s = 1'b1; // hready as the next rising edge sees it
  logic rd_ph = 1'b0; // read data phase under way
  logic [31:0] exp_q[$]; // expected read data
  int failures = 0;
  int samples_checked = 0;
  int rst_cnt = 0; // reset request pulses seen
  int n;
  always #5 i_clk = ~i_clk;
  // ----------------------------------------
  // design
  // ----------------------------------------
  sct_system_timer u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_slow_clock(slow), .i_hsel(1'b1),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hready(hreadyout), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_irq(irq), .o_guard_overflow_out_n(ovf_n), .o_reset_request(rst_req));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // mid-cycle monitor: read data against oldest note
  always @(negedge i_clk) begin
    rdy_s = hreadyout;
    if (rst_req === 1'b1) begin
      rst_cnt++;
    end
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
      chk(hrdata, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  // one single ahb transfer, waits on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge i_clk); while (rdy_s !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph = !wr;
    if (!wr) begin
      exp_q.push_back(e);
    end
    do @(posedge i_clk); while (rdy_s !== 1'b1);
    rd_ph = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, e);
  endtask
  // slow clock rising edges, each level held 4 cycles
  task automatic ticks(input int k);
    repeat (k) begin
      slow <= 1'b1;
      repeat (4) @(posedge i_clk);
      slow <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'haec21653));
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    // reset values, unmapped and read-only places
    chk({31'h0, ovf_n}, 32'h1);
    rd(OFS_INTERVAL_MODE, 32'h0);
    rd(OFS_WATCHDOG_MODE, 32'h20000);
    rd(OFS_SECONDS_MODE, 32'h8000);
    rd(OFS_TIMER_STATUS, 32'h0);
    rd(OFS_SECONDS_ALARM, 32'h0);
    wr(OFS_SECONDS_CURRENT, 32'h5);
    rd(OFS_SECONDS_CURRENT, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset_values done");
    // mask set and clear
    wr(OFS_IRQ_ENABLE, 32'hf);
    wr(OFS_IRQ_DISABLE, 32'h5);
    rd(OFS_IRQ_MASK, 32'ha);
    wr(OFS_IRQ_DISABLE, 32'ha);
    wr(OFS_IRQ_ENABLE, 32'h1);
    rd(OFS_IRQ_MASK, 32'h1);
    $display("test irq_mask done");
    // interval tick, random period, auto reload
    n = 2 + ($urandom % 8);
    wr(OFS_INTERVAL_MODE, n);
    rd(OFS_INTERVAL_MODE, n);
    ticks(n - 1);
    rd(OFS_TIMER_STATUS, 32'h0);
    ticks(1);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_TIMER_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    ticks(n);
    rd(OFS_TIMER_STATUS, 32'h1);
    $display("test interval done");
    // seconds counter, prescale 3, alarm at 2
    wr(OFS_INTERVAL_MODE, 32'h0);
    wr(OFS_SECONDS_ALARM, 32'h2);
    wr(OFS_SECONDS_MODE, 32'h3);
    ticks(6);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_SECONDS_CURRENT, 32'h2);
    rd(OFS_SECONDS_CURRENT, 32'h2);
    rd(OFS_TIMER_STATUS, 32'hc);
    rd(OFS_TIMER_STATUS, 32'h0);
    wr(OFS_SECONDS_MODE, 32'h3);
    rd(OFS_SECONDS_CURRENT, 32'h0);
    wr(OFS_SECONDS_MODE, 32'h0);
    $display("test seconds done");
    // watchdog: mode write alone, restart, overflow, pin, reload
    wr(OFS_WATCHDOG_MODE, 32'h30002);
    rd(OFS_WATCHDOG_MODE, 32'h30002);
    wr(OFS_TIMER_CONTROL, 32'h0);
    ticks(300);
    rd(OFS_TIMER_STATUS, 32'h0);
    wr(OFS_TIMER_CONTROL, 32'h1);
    ticks(255);
    rd(OFS_TIMER_STATUS, 32'h0);
    chk({31'h0, ovf_n}, 32'h1);
    ticks(1);
    chk({31'h0, ovf_n}, 32'h0);
    chk(rst_cnt, 32'h1);
    rd(OFS_TIMER_STATUS, 32'h2);
    ticks(7);
    chk({31'h0, ovf_n}, 32'h0);
    ticks(1);
    chk({31'h0, ovf_n}, 32'h1);
    ticks(247);
    chk(rst_cnt, 32'h1);
    ticks(1);
    chk(rst_cnt, 32'h2);
    $display("test watchdog done");
    close_out();
  end
  // watchdog on the whole run
  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule
